//--- rtl/dg_pkg.sv
// shared constants for the link diagnostics block
package dg_pkg;
	// management register offsets
	localparam logic [7:0] SIGCOND_ADDR = 8'h01;
	localparam logic [7:0] PATCTL_ADDR  = 8'hb7;
	localparam logic [7:0] ERRB3_ADDR   = 8'hb8;
	localparam logic [7:0] ERRB2_ADDR   = 8'hb9;
	localparam logic [7:0] ERRB1_ADDR   = 8'hba;
	localparam logic [7:0] ERRB0_ADDR   = 8'hbb;
	// field positions
	localparam int TX_EN_BIT   = 0;
	localparam int RX_EN_BIT   = 1;
	localparam int SYNC_BIT    = 4;
	localparam int CLR_BIT     = 7;
	localparam int HOST_LB_BIT = 1;
	localparam int LINE_LB_BIT = 2;
	// writable bits of the pattern control byte
	localparam logic [7:0] PATCTL_WMASK = 8'h6f;
	// values after reset
	localparam logic [7:0]  SIGCOND_RST = 8'h00;
	localparam logic [7:0]  PATCTL_RST  = 8'h00;
	localparam logic [30:0] PRBS_SEED   = 31'h7fff_ffff;
	// pattern sync hysteresis, in payload words
	localparam logic [3:0] LOCK_RUN = 4'h8;
	localparam logic [3:0] LOSS_RUN = 4'h4;
	// margin indicator
	localparam logic [3:0] MARGIN_MIN = 4'h3;
	localparam logic [3:0] MARGIN_MAX = 4'hc;
	localparam logic [3:0] ALARM_LVL  = 4'h5;
	localparam logic [3:0] MANT_MAX   = 4'h9;
	// averaging window
	localparam int CLK_HZ     = 50_000_000;
	localparam int WINDOW_S   = 25;
	localparam int WINDOW_CYC = CLK_HZ * WINDOW_S;
endpackage : dg_pkg

//--- rtl/prbs31_lane.sv
// prbs-31 lane: W pattern bits per step, free running or fed from data
`timescale 1ns/1ps
`default_nettype none
module prbs31_lane #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	// stepping
	input  wire logic         adv_i,
	input  wire logic         feed_i,
	input  wire logic [W-1:0] feed_bits_i,
	// pattern
	output logic      [W-1:0] bits_o,
	output logic              zero_o
);
	logic [30:0] st_q;
	logic [30:0] st_d;
	logic [30:0] t;

	// x^31 + x^28 + 1, first bit in msb; feeding lets a checker self-seed
	always_comb begin
		t = st_q;
		for (int k = W - 1; k >= 0; k--) begin
			bits_o[k] = t[30] ^ t[27];
			t = {t[29:0], feed_i ? feed_bits_i[k] : bits_o[k]};
		end
		st_d = adv_i ? t : st_q;
	end

	assign zero_o = st_q == 31'h0000_0000;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= dg_pkg::PRBS_SEED;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end
endmodule : prbs31_lane
`default_nettype wire

//--- rtl/stream_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	// fill side
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	// drain side
	output logic      [W-1:0] out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wp_q;
	logic [AW:0]  wp_d;
	logic [AW:0]  rp_q;
	logic [AW:0]  rp_d;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	// depth must be a power of two: wrap bit tells full from empty
	assign full        = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign empty       = wp_q == rp_q;
	assign in_ready_o  = ce_i && !full;
	assign out_valid_o = ce_i && !empty;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rp_q[AW-1:0]];

	always_comb begin
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// storage needs no reset; only written words are ever read
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule : stream_fifo
`default_nettype wire

//--- rtl/otn_link_diag.sv
// link diagnostics: pattern test, margin indicator and loopbacks
`timescale 1ns/1ps
`default_nettype none
module otn_link_diag #(
	parameter int W       = 8,
	parameter int DEPTH   = 8,
	parameter int WIN_CYC = dg_pkg::WINDOW_CYC,
	parameter int NBINS   = 5
) (
	// clock, reset, enable
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	// management registers
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic [7:0]   reg_wdata_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	output logic      [7:0]   reg_rdata_o,
	output logic              reg_rvalid_o,
	// host transmit stream in
	input  wire logic [W-1:0] htx_data_i,
	input  wire logic         htx_payload_i,
	input  wire logic         htx_valid_i,
	output logic              htx_ready_o,
	// line transmit stream out
	output logic      [W-1:0] ltx_data_o,
	output logic              ltx_payload_o,
	output logic              ltx_valid_o,
	input  wire logic         ltx_ready_i,
	// line receive stream in
	input  wire logic [W-1:0] lrx_raw_i,
	input  wire logic [W-1:0] lrx_corr_i,
	input  wire logic         lrx_payload_i,
	input  wire logic         lrx_valid_i,
	input  wire logic         fec_on_i,
	// host receive stream out
	output logic      [W-1:0] hrx_data_o,
	output logic              hrx_valid_o,
	// fec statistics and margin
	input  wire logic [7:0]   fec_corr_bits_i,
	input  wire logic         link_fail_i,
	output logic      [3:0]   margin_int_o,
	output logic      [3:0]   margin_mant_o,
	output logic              bias_low_alarm_o
);
	typedef enum logic [1:0] {
		S_HUNT = 2'b01,
		S_LOCK = 2'b10
	} sync_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_EXP  = 3'b010,
		M_MANT = 3'b100
	} mcalc_t;

	localparam logic [63:0] WBITS    = 64'(WIN_CYC) * 64'(W);
	localparam logic [31:0] BIN_LAST = 32'(WIN_CYC / NBINS - 1);

	// register state
	logic [7:0]   sc_q;
	logic [7:0]   sc_d;
	logic [7:0]   pc_q;
	logic [7:0]   pc_d;
	logic [7:0]   rd_q;
	logic [7:0]   rd_d;
	logic         clr_q;
	logic         clr_d;
	logic         rv_q;
	logic         rv_d;
	logic [31:0]  cnt_q;
	logic [31:0]  cnt_d;
	logic [31:0]  snap_q;
	logic [31:0]  snap_d;
	logic         wr_sc;
	logic         wr_pc;
	logic         tx_en;
	logic         rx_en;
	logic         host_lb;
	logic         line_lb;
	// data paths
	logic [W-1:0] gen_bits;
	logic [W-1:0] src_data;
	logic [W-1:0] push_data;
	logic         src_pay;
	logic         src_valid;
	logic         push_ready;
	logic         gen_adv;
	logic [W:0]   fifo_out;
	logic [W-1:0] hrx_q;
	logic [W-1:0] hrx_d;
	logic         hv_q;
	logic         hv_d;
	// checker
	logic [W-1:0] rx_bits;
	logic [W-1:0] exp_bits;
	logic [W-1:0] err_vec;
	logic [7:0]   errs;
	logic [32:0]  sum;
	logic         chk_adv;
	logic         exp_zero;
	sync_t        sy_q;
	sync_t        sy_d;
	logic [3:0]   run_q;
	logic [3:0]   run_d;
	// margin
	logic [31:0]  cyc_q;
	logic [31:0]  cyc_d;
	logic [39:0]  acc_q;
	logic [39:0]  acc_d;
	logic [39:0]  acc_in;
	logic [39:0]  bin_q [NBINS];
	logic [39:0]  bin_d [NBINS];
	logic [39:0]  wsum_q;
	logic [39:0]  wsum_d;
	logic         bin_end;
	mcalc_t       m_q;
	mcalc_t       m_d;
	logic [63:0]  scl_q;
	logic [63:0]  scl_d;
	logic [3:0]   ex_q;
	logic [3:0]   ex_d;
	logic [3:0]   mn_q;
	logic [3:0]   mn_d;
	logic [3:0]   mi_q;
	logic [3:0]   mi_d;
	logic [3:0]   mm_q;
	logic [3:0]   mm_d;
	logic         al_q;
	logic         al_d;

	// register access
	assign wr_sc   = reg_wr_i && reg_addr_i == dg_pkg::SIGCOND_ADDR;
	assign wr_pc   = reg_wr_i && reg_addr_i == dg_pkg::PATCTL_ADDR;
	assign tx_en   = pc_q[dg_pkg::TX_EN_BIT];
	assign rx_en   = pc_q[dg_pkg::RX_EN_BIT];
	assign host_lb = sc_q[dg_pkg::HOST_LB_BIT];
	assign line_lb = sc_q[dg_pkg::LINE_LB_BIT];

	always_comb begin
		sc_d   = wr_sc ? reg_wdata_i : sc_q;
		pc_d   = wr_pc ? (reg_wdata_i & dg_pkg::PATCTL_WMASK) : pc_q;
		clr_d  = wr_pc && reg_wdata_i[dg_pkg::CLR_BIT];
		snap_d = (reg_rd_i && reg_addr_i == dg_pkg::ERRB3_ADDR) ? cnt_q : snap_q;
		rv_d   = reg_rd_i;
		rd_d   = rd_q;
		if (reg_rd_i) begin
			case (reg_addr_i)
				dg_pkg::SIGCOND_ADDR: rd_d = sc_q;
				dg_pkg::PATCTL_ADDR: begin
					rd_d = pc_q;
					rd_d[dg_pkg::CLR_BIT]  = clr_q;
					rd_d[dg_pkg::SYNC_BIT] = sy_q != S_LOCK;
				end
				dg_pkg::ERRB3_ADDR: rd_d = cnt_q[31:24];
				dg_pkg::ERRB2_ADDR: rd_d = snap_q[23:16];
				dg_pkg::ERRB1_ADDR: rd_d = snap_q[15:8];
				dg_pkg::ERRB0_ADDR: rd_d = snap_q[7:0];
				default: rd_d = 8'h00;
			endcase
		end
	end

	// transmit: loopback source, pattern insertion, buffering
	assign src_data    = line_lb ? lrx_raw_i : htx_data_i;
	assign src_pay     = line_lb ? lrx_payload_i : htx_payload_i;
	assign src_valid   = line_lb ? lrx_valid_i : htx_valid_i;
	// host traffic is dropped, not stalled, while the line is looped
	assign htx_ready_o = line_lb || push_ready;
	assign gen_adv     = src_valid && push_ready && src_pay && tx_en && !line_lb;
	assign push_data   = gen_adv ? gen_bits : src_data;

	prbs31_lane #(.W(W)) u_gen (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.adv_i       (gen_adv),
		.feed_i      (1'b0),
		.feed_bits_i ({W{1'b0}}),
		.bits_o      (gen_bits),
		.zero_o      ()
	);

	stream_fifo #(.W(W + 1), .DEPTH(DEPTH)) u_fifo (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.in_data_i   ({src_pay, push_data}),
		.in_valid_i  (src_valid),
		.in_ready_o  (push_ready),
		.out_data_o  (fifo_out),
		.out_valid_o (ltx_valid_o),
		.out_ready_i (ltx_ready_i)
	);

	assign ltx_payload_o = fifo_out[W];
	assign ltx_data_o    = fifo_out[W-1:0];

	// receive: host loopback and pattern checker
	assign rx_bits = fec_on_i ? lrx_corr_i : lrx_raw_i;
	assign chk_adv = rx_en && lrx_valid_i && lrx_payload_i;
	assign err_vec = rx_bits ^ exp_bits;

	// hunting feeds received bits in, so lock needs no seed search
	prbs31_lane #(.W(W)) u_chk (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.adv_i       (chk_adv),
		.feed_i      (sy_q != S_LOCK),
		.feed_bits_i (rx_bits),
		.bits_o      (exp_bits),
		.zero_o      (exp_zero)
	);

	always_comb begin
		hrx_d = host_lb ? htx_data_i : rx_bits;
		hv_d  = host_lb ? htx_valid_i : lrx_valid_i;
		errs  = 8'h00;
		for (int k = 0; k < W; k++) begin
			errs = errs + 8'(err_vec[k]);
		end
		sum   = {1'b0, cnt_q} + 33'(errs);
		cnt_d = cnt_q;
		// a clear keeps the errors of its own cycle
		if (clr_q) begin
			cnt_d = chk_adv ? 32'(errs) : 32'h0000_0000;
		end else if (chk_adv) begin
			cnt_d = sum[32] ? 32'hffff_ffff : sum[31:0];
		end
	end

	// pattern sync: an all-zero stream never counts as locked
	always_comb begin
		sy_d  = sy_q;
		run_d = run_q;
		case (sy_q)
			S_HUNT: begin
				if (!rx_en || (chk_adv && (errs != 8'h00 || exp_zero))) begin
					run_d = 4'h0;
				end else if (chk_adv && run_q == dg_pkg::LOCK_RUN - 4'h1) begin
					sy_d  = S_LOCK;
					run_d = 4'h0;
				end else if (chk_adv) begin
					run_d = run_q + 4'h1;
				end
			end
			S_LOCK: begin
				if (!rx_en || (chk_adv && errs != 8'h00 && run_q == dg_pkg::LOSS_RUN - 4'h1)) begin
					sy_d  = S_HUNT;
					run_d = 4'h0;
				end else if (chk_adv) begin
					run_d = (errs == 8'h00) ? 4'h0 : run_q + 4'h1;
				end
			end
			default: begin
				sy_d  = S_HUNT;
				run_d = 4'h0;
			end
		endcase
	end

	// margin: NBINS sub-windows form a rolling window
	assign bin_end = cyc_q == BIN_LAST;
	assign acc_in  = acc_q + 40'(fec_corr_bits_i);

	always_comb begin
		cyc_d  = bin_end ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
		acc_d  = bin_end ? 40'h0 : acc_in;
		bin_d  = bin_q;
		wsum_d = wsum_q;
		if (bin_end) begin
			for (int k = NBINS - 1; k > 0; k--) begin
				bin_d[k] = bin_q[k-1];
			end
			bin_d[0] = acc_in;
			wsum_d   = wsum_q - bin_q[NBINS-1] + acc_in;
		end
	end

	// rate = errors / window bits, turned into exponent and mantissa
	always_comb begin
		m_d   = m_q;
		scl_d = scl_q;
		ex_d  = ex_q;
		mn_d  = mn_q;
		mi_d  = mi_q;
		mm_d  = mm_q;
		case (m_q)
			M_IDLE: begin
				if (bin_end && wsum_d == 40'h0) begin
					mi_d = dg_pkg::MARGIN_MAX;
					mm_d = 4'h0;
				end else if (bin_end) begin
					scl_d = {24'h0, wsum_d};
					ex_d  = 4'h0;
					m_d   = M_EXP;
				end
			end
			M_EXP: begin
				if (scl_q >= WBITS) begin
					mn_d = 4'h0;
					m_d  = M_MANT;
				end else if (ex_q == dg_pkg::MARGIN_MAX) begin
					mi_d = dg_pkg::MARGIN_MAX;
					mm_d = 4'h0;
					m_d  = M_IDLE;
				end else begin
					scl_d = (scl_q << 3) + (scl_q << 1);
					ex_d  = ex_q + 4'h1;
				end
			end
			M_MANT: begin
				if (scl_q >= WBITS && mn_q != dg_pkg::MANT_MAX) begin
					scl_d = scl_q - WBITS;
					mn_d  = mn_q + 4'h1;
				end else if (ex_q < dg_pkg::MARGIN_MIN) begin
					mi_d = dg_pkg::MARGIN_MIN;
					mm_d = dg_pkg::MANT_MAX;
					m_d  = M_IDLE;
				end else begin
					mi_d = ex_q;
					mm_d = mn_q;
					m_d  = M_IDLE;
				end
			end
			default: m_d = M_IDLE;
		endcase
		if (link_fail_i) begin
			mi_d = dg_pkg::MARGIN_MAX;
			mm_d = 4'h0;
		end
		al_d = mi_d < dg_pkg::ALARM_LVL;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sc_q   <= dg_pkg::SIGCOND_RST;
			pc_q   <= dg_pkg::PATCTL_RST;
			rd_q   <= 8'h00;
			clr_q  <= 1'b0;
			rv_q   <= 1'b0;
			cnt_q  <= 32'h0000_0000;
			snap_q <= 32'h0000_0000;
			hrx_q  <= '0;
			hv_q   <= 1'b0;
			sy_q   <= S_HUNT;
			run_q  <= 4'h0;
			cyc_q  <= 32'h0000_0000;
			acc_q  <= 40'h0;
			wsum_q <= 40'h0;
			for (int k = 0; k < NBINS; k++) begin
				bin_q[k] <= 40'h0;
			end
			m_q    <= M_IDLE;
			scl_q  <= 64'h0;
			ex_q   <= 4'h0;
			mn_q   <= 4'h0;
			mi_q   <= dg_pkg::MARGIN_MAX;
			mm_q   <= 4'h0;
			al_q   <= 1'b0;
		end else if (ce_i) begin
			sc_q   <= sc_d;
			pc_q   <= pc_d;
			rd_q   <= rd_d;
			clr_q  <= clr_d;
			rv_q   <= rv_d;
			cnt_q  <= cnt_d;
			snap_q <= snap_d;
			hrx_q  <= hrx_d;
			hv_q   <= hv_d;
			sy_q   <= sy_d;
			run_q  <= run_d;
			cyc_q  <= cyc_d;
			acc_q  <= acc_d;
			wsum_q <= wsum_d;
			bin_q  <= bin_d;
			m_q    <= m_d;
			scl_q  <= scl_d;
			ex_q   <= ex_d;
			mn_q   <= mn_d;
			mi_q   <= mi_d;
			mm_q   <= mm_d;
			al_q   <= al_d;
		end
	end

	assign reg_rdata_o      = rd_q;
	assign reg_rvalid_o     = rv_q;
	assign hrx_data_o       = hrx_q;
	assign hrx_valid_o      = hv_q;
	assign margin_int_o     = mi_q;
	assign margin_mant_o    = mm_q;
	assign bias_low_alarm_o = al_q;

	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_clr_write;
		ce_i && wr_pc && reg_wdata_i[dg_pkg::CLR_BIT];
	endsequence

	sequence s_clr_taken;
		s_clr_write ##1 (clr_q && ce_i && !chk_adv);
	endsequence

	a_tx_pattern: assert property (
		htx_valid_i && htx_ready_o && htx_payload_i && tx_en && !line_lb
		|-> push_data == gen_bits)
		else $error("payload not replaced by pattern");
	a_overhead_pass: assert property (
		htx_valid_i && htx_ready_o && !htx_payload_i && !line_lb
		|-> push_data == htx_data_i)
		else $error("overhead altered");
	a_count_step: assert property (
		ce_i && chk_adv && !clr_q && cnt_q < 32'hffff_ff00
		|=> cnt_q == $past(cnt_q) + 32'($past(errs)))
		else $error("error count step wrong");
	a_count_hold: assert property (
		ce_i && !rx_en && !clr_q |=> $stable(cnt_q))
		else $error("count moved while checking off");
	a_count_sat: assert property (
		ce_i && cnt_q == 32'hffff_ffff && !clr_q |=> cnt_q == 32'hffff_ffff)
		else $error("count wrapped");
	a_clear_self: assert property (
		s_clr_taken |=> cnt_q == 32'h0000_0000 && !clr_q)
		else $error("clear did not act or stick");
	a_sync_read: assert property (
		ce_i && reg_rd_i && reg_addr_i == dg_pkg::PATCTL_ADDR
		|=> reg_rvalid_o && reg_rdata_o[dg_pkg::SYNC_BIT] == ($past(sy_q) != S_LOCK))
		else $error("sync status read wrong");
	a_snap_read: assert property (
		ce_i && reg_rd_i && reg_addr_i == dg_pkg::ERRB0_ADDR
		|=> reg_rdata_o == 8'($past(snap_q)))
		else $error("low count byte not from snapshot");
	a_margin_range: assert property (
		margin_int_o >= dg_pkg::MARGIN_MIN && margin_int_o <= dg_pkg::MARGIN_MAX)
		else $error("margin out of range");
	a_fail_twelve: assert property (
		ce_i && link_fail_i |=> margin_int_o == 4'hc && !bias_low_alarm_o)
		else $error("failed link not shown as 12");
	a_low_alarm: assert property (
		bias_low_alarm_o == (margin_int_o < dg_pkg::ALARM_LVL))
		else $error("bias low alarm mismatch");
	a_host_loop: assert property (
		ce_i && host_lb |=> hrx_data_o == $past(htx_data_i) && hrx_valid_o == $past(htx_valid_i))
		else $error("host loopback broken");
	a_line_loop: assert property (
		line_lb && lrx_valid_i && push_ready |-> push_data == lrx_raw_i)
		else $error("line loopback broken");
endmodule : otn_link_diag
`default_nettype wire

//--- dv/line_loop_model.sv
// line side model: every transmitted word comes back as a received word
`timescale 1ns/1ps
`default_nettype none
module line_loop_model (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// bench control
	input  wire logic       stall_i,
	input  wire logic       flip_ld_i,
	input  wire logic [7:0] flip_i,
	// line transmit sink
	input  wire logic [7:0] ltx_data_i,
	input  wire logic       ltx_payload_i,
	input  wire logic       ltx_valid_i,
	output logic            ltx_ready_o,
	// line receive source
	output logic      [7:0] lrx_raw_o,
	output logic      [7:0] lrx_corr_o,
	output logic            lrx_payload_o,
	output logic            lrx_valid_o
);
	logic [7:0] pend_q;
	assign ltx_ready_o = !stall_i;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= 8'h00;
			lrx_raw_o <= 8'h00;
			lrx_corr_o <= 8'h00;
			lrx_payload_o <= 1'b0;
			lrx_valid_o <= 1'b0;
		end else if (ltx_valid_i && !stall_i) begin
			// raw copy carries the injected error, corrected copy is clean
			lrx_raw_o <= ltx_data_i ^ (ltx_payload_i ? pend_q : 8'h00);
			lrx_corr_o <= ltx_data_i;
			lrx_payload_o <= ltx_payload_i;
			lrx_valid_o <= 1'b1;
			pend_q <= flip_ld_i ? flip_i : (ltx_payload_i ? 8'h00 : pend_q);
		end else begin
			// idle line never holds its last word
			lrx_raw_o <= ~lrx_raw_o;
			lrx_corr_o <= ~lrx_corr_o;
			lrx_valid_o <= 1'b0;
			pend_q <= flip_ld_i ? flip_i : pend_q;
		end
	end
endmodule : line_loop_model
`default_nettype wire

//--- dv/otn_link_test_diagnostics_bench.sv
// self-checking bench for the link diagnostics block
`timescale 1ns/1ps
`default_nettype none
module otn_link_test_diagnostics_bench;
	logic       mclk_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, htx_data_i, ltx_data_o;
	logic       htx_payload_i, htx_valid_i, htx_ready_o, ltx_payload_o, ltx_valid_o;
	logic       ltx_ready_i, lrx_payload_i, lrx_valid_i, fec_on_i, hrx_valid_o;
	logic [7:0] lrx_raw_i, lrx_corr_i, hrx_data_o, fec_corr_bits_i, flip_i;
	logic       link_fail_i, bias_low_alarm_o, stall_i, flip_ld_i;
	logic [3:0] margin_int_o, margin_mant_o;
	logic [7:0] hq[$];
	int         num_errors, samples_checked;

	otn_link_diag #(.W(8), .DEPTH(8), .WIN_CYC(10000), .NBINS(5)) u_otn_link_diag (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.htx_data_i(htx_data_i), .htx_payload_i(htx_payload_i), .htx_valid_i(htx_valid_i),
		.htx_ready_o(htx_ready_o), .ltx_data_o(ltx_data_o), .ltx_payload_o(ltx_payload_o),
		.ltx_valid_o(ltx_valid_o), .ltx_ready_i(ltx_ready_i), .lrx_raw_i(lrx_raw_i),
		.lrx_corr_i(lrx_corr_i), .lrx_payload_i(lrx_payload_i), .lrx_valid_i(lrx_valid_i),
		.fec_on_i(fec_on_i), .hrx_data_o(hrx_data_o), .hrx_valid_o(hrx_valid_o),
		.fec_corr_bits_i(fec_corr_bits_i), .link_fail_i(link_fail_i),
		.margin_int_o(margin_int_o), .margin_mant_o(margin_mant_o),
		.bias_low_alarm_o(bias_low_alarm_o));
	line_loop_model u_line_loop_model (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .stall_i(stall_i), .flip_ld_i(flip_ld_i),
		.flip_i(flip_i), .ltx_data_i(ltx_data_o), .ltx_payload_i(ltx_payload_o),
		.ltx_valid_i(ltx_valid_o), .ltx_ready_o(ltx_ready_i), .lrx_raw_o(lrx_raw_i),
		.lrx_corr_o(lrx_corr_i), .lrx_payload_o(lrx_payload_i), .lrx_valid_o(lrx_valid_i));

	always #10 mclk_i = ~mclk_i;
	// negedge capture avoids racing the registered host output
	always @(negedge mclk_i) if (hrx_valid_o === 1'b1) hq.push_back(hrx_data_o);

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step;
		@(posedge mclk_i);
		#1;
	endtask : step
	// host reaches the controls only through register writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		step();
		reg_wr_i = 1'b0;
		// idle edge so a following strobe never toggles twice in one step
		step();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		step();
		reg_rd_i = 1'b0;
		chk(reg_rvalid_o, 1);
		d = reg_rdata_o;
		step();
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rdc
	// msb first, so the snapshot covers the other three bytes
	task automatic cntc(input logic [31:0] e);
		logic [7:0] b3, b2, b1, b0;
		rd(8'hb8, b3);
		rd(8'hb9, b2);
		rd(8'hba, b1);
		rd(8'hbb, b0);
		chk({b3, b2, b1, b0}, e);
	endtask : cntc
	task automatic send(input logic [7:0] d, input logic p);
		logic ok;
		ok = 1'b0;
		htx_data_i = d;
		htx_payload_i = p;
		htx_valid_i = 1'b1;
		for (int i = 0; i < 50 && !ok; i++) begin
			#17;
			ok = htx_ready_o === 1'b1;
			step();
		end
		htx_valid_i = 1'b0;
		step();
		if (!ok) begin num_errors++; end_of_test(); end
	endtask : send
	task automatic get(output logic [7:0] d);
		for (int i = 0; i < 100 && hq.size() == 0; i++) step();
		if (hq.size() == 0) begin num_errors++; end_of_test(); end
		d = hq.pop_front();
	endtask : get
	task automatic getc(input logic [7:0] e);
		logic [7:0] d;
		get(d);
		chk(d, e);
	endtask : getc
	task automatic flip(input logic [7:0] m);
		flip_i = m;
		flip_ld_i = 1'b1;
		step();
		flip_ld_i = 1'b0;
	endtask : flip
	task automatic mwait(input logic [3:0] ei, input logic [3:0] em, input logic ea);
		for (int i = 0; i < 2500 && margin_int_o !== ei; i++) step();
		if (margin_int_o !== ei) begin num_errors++; end_of_test(); end
		step();
		step();
		chk({margin_int_o, margin_mant_o, 3'b000, bias_low_alarm_o}, {ei, em, 3'b000, ea});
	endtask : mwait

	task automatic t_regs;
		chk({margin_int_o, margin_mant_o}, 8'hc0);
		rdc(8'h01, 8'h00);
		rdc(8'hb7, 8'h10);
		rdc(8'h55, 8'h00);
		wr(8'h01, 8'hff);
		rdc(8'h01, 8'hff);
		wr(8'h01, 8'h00);
		wr(8'hb7, 8'h6c);
		rdc(8'hb7, 8'h7c);
		wr(8'hb7, 8'h00);
		cntc(32'h0000_0000);
		$display("register test done");
	endtask : t_regs
	task automatic t_prbs;
		logic [7:0] d, acc;
		acc = 8'h00;
		hq.delete();
		send(8'h3c, 1'b1);
		getc(8'h3c);
		wr(8'hb7, 8'h03);
		for (int i = 0; i < 20; i++) send(8'h00, 1'b1);
		for (int i = 0; i < 20; i++) begin get(d); acc = acc | d; end
		chk(acc != 8'h00, 1);
		wr(8'hb7, 8'h83);
		step();
		rdc(8'hb7, 8'h03);
		cntc(32'h0000_0000);
		send(8'h5a, 1'b0);
		getc(8'h5a);
		flip(8'h07);
		send(8'h00, 1'b1);
		get(d);
		cntc(32'h0000_0003);
		fec_on_i = 1'b1;
		flip(8'h01);
		send(8'h00, 1'b1);
		get(d);
		cntc(32'h0000_0003);
		fec_on_i = 1'b0;
		wr(8'hb7, 8'h01);
		flip(8'hff);
		send(8'h00, 1'b1);
		get(d);
		cntc(32'h0000_0003);
		rdc(8'hb7, 8'h11);
		wr(8'hb7, 8'h81);
		rdc(8'hb7, 8'h11);
		cntc(32'h0000_0000);
		$display("pattern test done");
	endtask : t_prbs
	task automatic t_fifo;
		wr(8'hb7, 8'h00);
		hq.delete();
		stall_i = 1'b1;
		for (int i = 0; i < 8; i++) send(8'h10 + 8'(i), 1'b1);
		#17;
		chk(htx_ready_o, 0);
		step();
		wr(8'h01, 8'h04);
		#17;
		chk(htx_ready_o, 1);
		step();
		wr(8'h01, 8'h00);
		stall_i = 1'b0;
		for (int i = 0; i < 8; i++) getc(8'h10 + 8'(i));
		wr(8'h01, 8'h02);
		send(8'h96, 1'b1);
		getc(8'h96);
		wr(8'h01, 8'h00);
		$display("buffer and loopback test done");
	endtask : t_fifo
	task automatic t_margin;
		fec_corr_bits_i = 8'h01;
		step();
		fec_corr_bits_i = 8'h00;
		mwait(4'h5, 4'h1, 1'b0);
		fec_corr_bits_i = 8'h07;
		step();
		fec_corr_bits_i = 8'h00;
		mwait(4'h4, 4'h1, 1'b1);
		chk(margin_int_o <= 4'h4, 1);
		fec_corr_bits_i = 8'hff;
		repeat (10) step();
		fec_corr_bits_i = 8'h00;
		mwait(4'h3, 4'h9, 1'b1);
		link_fail_i = 1'b1;
		mwait(4'hc, 4'h0, 1'b0);
		link_fail_i = 1'b0;
		$display("margin test done");
	endtask : t_margin

	initial begin
		{mclk_i, rst_n_i, reg_wr_i, reg_rd_i, htx_payload_i, htx_valid_i} = '0;
		{fec_on_i, link_fail_i, stall_i, flip_ld_i} = '0;
		{reg_addr_i, reg_wdata_i, htx_data_i, fec_corr_bits_i, flip_i} = '0;
		ce_i = 1'b1;
		num_errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		step();
		t_regs();
		t_prbs();
		t_fifo();
		t_margin();
		end_of_test();
	end
endmodule : otn_link_test_diagnostics_bench
`default_nettype wire
